// ===== src/lvic_ctrl.sv
`timescale 1ns/10ps
module lvic_ctrl #(
  parameter logic [15:0] RESET_VECTOR = lvic_pkg::RESET_VEC_DFLT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [lvic_pkg::NUM_SRC-1:0] SRC_EVENT,
  input wire logic [lvic_pkg::NUM_SRC-1:0] SRC_EN,
  input wire logic [lvic_pkg::NUM_SRC-1:0] SW_CLR,
  input wire logic [lvic_pkg::NUM_LVL-1:0] LEVEL_MASK_REG,
  input wire logic [7:0] LEVEL_PRIORITY_REG,
  input wire logic GLOBAL_INT_ON_INSTR,
  input wire logic GLOBAL_INT_OFF_INSTR,
  input wire logic CPU_BOUNDARY,
  input wire logic [15:0] CPU_PC,
  input wire logic [7:0] CPU_FLAGS,
  input wire logic [15:0] CPU_SP,
  input wire logic MEM_ACK,
  input wire logic [7:0] MEM_RDATA,
  output logic [lvic_pkg::NUM_SRC-1:0] SRC_PEND,
  output logic [lvic_pkg::NUM_LVL-1:0] REQUEST_LEVEL_N,
  output logic SYSTEM_MODE_GIE,
  output logic IN_SERVICE,
  output logic [2:0] SVC_LEVEL,
  output logic [7:0] SVC_VECTOR,
  output logic MEM_REQ,
  output logic MEM_WR,
  output logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  output logic PC_LOAD,
  output logic [15:0] PC_VALUE,
  output logic [15:0] SP_VALUE,
  output logic RESET_REQ,
  output logic [15:0] RESET_ADDR
);
  import lvic_pkg::*;

  logic [NUM_SRC-1:0] pend_r;
  logic [NUM_SRC-1:0] pend_nxt;
  logic [NUM_SRC-1:0] act;
  logic [NUM_SRC-1:0] hw_clr;
  logic [NUM_LVL-1:0] lvl_raw;
  logic [NUM_LVL-1:0] elig;
  logic [NUM_LVL-1:0] req_r;
  logic gie_r;
  logic [3:0] win;
  logic win_valid;
  logic [2:0] win_lvl;
  logic [7:0] win_vec;
  logic [4:0] win_src;
  logic grant;
  logic bt_fire;
  lvic_state_e state_r;
  logic [15:0] pc_r;
  logic [7:0] flags_r;
  logic [15:0] sp_r;
  logic [7:0] vec_r;
  logic [2:0] lvl_r;
  logic [7:0] hi_r;
  logic in_svc_r;
  logic mem_req_r;
  logic mem_wr_r;
  logic [15:0] mem_addr_r;
  logic [7:0] mem_wdata_r;
  logic pc_load_r;
  logic [15:0] pc_value_r;
  logic [15:0] sp_value_r;
  logic reset_req_r;
  logic [15:0] reset_addr_r;

  // ---------------------------------------------------------------
  // per-level arbiters
  // ---------------------------------------------------------------
  lvic_pick_if #(.N(2)) pk0 ();
  lvic_pick_if #(.N(2)) pk1 ();
  lvic_pick_if #(.N(1)) pk2 ();
  lvic_pick_if #(.N(2)) pk3 ();
  lvic_pick_if #(.N(1)) pk4 ();
  lvic_pick_if #(.N(4)) pk6 ();
  lvic_pick_if #(.N(1)) pk7 ();

  // only pending sources that are enabled take part
  assign act = pend_r & SRC_EN;

  // timer, capture and port pin level requests (levels 0 to 4, 6)
  assign pk0.req = {act[SRC_T0_MC], act[SRC_T0_OVF]};
  assign pk1.req = {act[SRC_T1_MC], act[SRC_T1_OVF]};
  assign pk2.req = act[SRC_CA];
  assign pk4.req = act[SRC_P2_0];
  assign pk3.req = {act[SRC_T2_MC], act[SRC_T2_OVF]};
  assign pk6.req = act[SRC_P0_3:SRC_P0_0];
  // four pins merged on one vector
  assign pk7.req = |act[SRC_P0_7:SRC_P0_4];

  lvic_level_pick #(.N(2)) u_pick0 (.pk(pk0));
  lvic_level_pick #(.N(2)) u_pick1 (.pk(pk1));
  lvic_level_pick #(.N(1)) u_pick2 (.pk(pk2));
  lvic_level_pick #(.N(2)) u_pick3 (.pk(pk3));
  lvic_level_pick #(.N(1)) u_pick4 (.pk(pk4));
  lvic_level_pick #(.N(4)) u_pick6 (.pk(pk6));
  lvic_level_pick #(.N(1)) u_pick7 (.pk(pk7));

  // ---------------------------------------------------------------
  // level requests and eligibility
  // ---------------------------------------------------------------
  // level five has no source
  assign lvl_raw = {pk7.any, pk6.any, 1'b0, pk4.any, pk3.any, pk2.any, pk1.any, pk0.any};
  // gate by mask and global enable
  assign elig = lvl_raw & LEVEL_MASK_REG & {NUM_LVL{gie_r}};

  // first valid of two encoded candidates
  function automatic logic [3:0] first2(input logic [3:0] a, input logic [3:0] b);
    first2 = a[3] ? a : b;
  endfunction

  // candidate code for one level
  function automatic logic [3:0] cand(input logic [7:0] e, input int l);
    cand = {e[l], 3'(l)};
  endfunction

  // level selection from groups and subgroups
  function automatic logic [3:0] pick_level(input logic [7:0] e, input logic [7:0] p);
    logic [3:0] wa;
    logic [3:0] wb;
    logic [3:0] wc;
    logic [3:0] sb;
    logic [3:0] sc;
    logic [2:0] ord;
    wa = p[PRIO_SUB_A] ? first2(cand(e, 1), cand(e, 0)) : first2(cand(e, 0), cand(e, 1));
    sb = p[PRIO_SUB_B] ? first2(cand(e, 4), cand(e, 3)) : first2(cand(e, 3), cand(e, 4));
    wb = p[PRIO_GRP_B] ? first2(sb, cand(e, 2)) : first2(cand(e, 2), sb);
    sc = p[PRIO_SUB_C] ? first2(cand(e, 7), cand(e, 6)) : first2(cand(e, 6), cand(e, 7));
    wc = p[PRIO_GRP_C] ? first2(sc, cand(e, 5)) : first2(cand(e, 5), sc);
    ord = {p[PRIO_ORD_HI], p[PRIO_ORD_MID], p[PRIO_ORD_LO]};
    case (ord)
      ORD_BCA: pick_level = first2(wb, first2(wc, wa));
      ORD_BAC: pick_level = first2(wb, first2(wa, wc));
      ORD_CAB: pick_level = first2(wc, first2(wa, wb));
      ORD_CBA: pick_level = first2(wc, first2(wb, wa));
      ORD_ACB: pick_level = first2(wa, first2(wc, wb));
      default: pick_level = first2(wa, first2(wb, wc));
    endcase
  endfunction

  assign win = pick_level(elig, LEVEL_PRIORITY_REG);
  assign win_valid = win[3];
  assign win_lvl = win[2:0];

  // ---------------------------------------------------------------
  // winning vector and source
  // ---------------------------------------------------------------
  // in-level winner maps to its vector
  always_comb begin
    win_vec = VEC_T0_OVF;
    win_src = 5'(SRC_T0_OVF);
    case (win_lvl)
      3'h0: begin
        win_vec = pk0.idx[0] ? VEC_T0_MC : VEC_T0_OVF;
        win_src = pk0.idx[0] ? 5'(SRC_T0_MC) : 5'(SRC_T0_OVF);
      end
      3'h1: begin
        win_vec = pk1.idx[0] ? VEC_T1_MC : VEC_T1_OVF;
        win_src = pk1.idx[0] ? 5'(SRC_T1_MC) : 5'(SRC_T1_OVF);
      end
      3'h2: begin
        win_vec = VEC_CA;
        win_src = 5'(SRC_CA);
      end
      3'h3: begin
        win_vec = pk3.idx[0] ? VEC_T2_MC : VEC_T2_OVF;
        win_src = pk3.idx[0] ? 5'(SRC_T2_MC) : 5'(SRC_T2_OVF);
      end
      3'h4: begin
        win_vec = VEC_P2_0;
        win_src = 5'(SRC_P2_0);
      end
      3'h6: begin
        win_vec = VEC_P0_0 + {5'h00, pk6.idx, 1'b0};
        win_src = 5'(SRC_P0_0) + {3'h0, pk6.idx};
      end
      3'h7: begin
        win_vec = VEC_P0_HI;
        win_src = 5'(SRC_P0_4);
      end
      default: begin
        win_vec = VEC_T0_OVF;
        win_src = 5'(SRC_T0_OVF);
      end
    endcase
  end

  // grant only between instructions while idle
  assign grant = (state_r == LV_IDLE) && CPU_BOUNDARY && win_valid;
  assign bt_fire = act[SRC_BT_OVF];

  // ---------------------------------------------------------------
  // pending bits
  // ---------------------------------------------------------------
  // hardware clear for served overflow and capture sources
  always_comb begin
    hw_clr = '0;
    if (grant) begin
      hw_clr = ({{(NUM_SRC-1){1'b0}}, 1'b1} << win_src) & SRC_HW_CLR;
    end
    if (bt_fire) begin
      hw_clr[SRC_BT_OVF] = 1'b1;
    end
  end

  // a new event wins over any clear in the same cycle
  assign pend_nxt = (pend_r & ~(SW_CLR | hw_clr)) | SRC_EVENT;

  // pending and request flags
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pend_r <= '0;
      req_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      req_r <= lvl_raw;
    end
  end

  // ---------------------------------------------------------------
  // global enable
  // ---------------------------------------------------------------
  // off from reset until the on instruction
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gie_r <= GIE_RST;
    end else if (grant) begin
      gie_r <= 1'b0;
    end else if (GLOBAL_INT_OFF_INSTR) begin
      gie_r <= 1'b0;
    end else if (GLOBAL_INT_ON_INSTR) begin
      gie_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // basic timer reset request
  // ---------------------------------------------------------------
  // overflow requests restart at the reset vector
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      reset_req_r <= 1'b0;
      reset_addr_r <= RESET_VEC_DFLT;
    end else begin
      reset_req_r <= bt_fire;
      reset_addr_r <= RESET_VECTOR;
    end
  end

  // ---------------------------------------------------------------
  // service sequencer
  // ---------------------------------------------------------------
  // push pc low, pc high, flags; fetch two vector bytes
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r <= LV_IDLE;
      pc_r <= 16'h0000;
      flags_r <= 8'h00;
      sp_r <= 16'h0000;
      vec_r <= 8'h00;
      lvl_r <= 3'h0;
      hi_r <= 8'h00;
      in_svc_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= 16'h0000;
      mem_wdata_r <= 8'h00;
      pc_load_r <= 1'b0;
      pc_value_r <= 16'h0000;
      sp_value_r <= 16'h0000;
    end else begin
      pc_load_r <= 1'b0;
      case (state_r)
        LV_IDLE: begin
          if (grant) begin
            pc_r <= CPU_PC;
            flags_r <= CPU_FLAGS;
            sp_r <= CPU_SP;
            vec_r <= win_vec;
            lvl_r <= win_lvl;
            in_svc_r <= 1'b1;
            mem_req_r <= 1'b1;
            mem_wr_r <= 1'b1;
            mem_addr_r <= CPU_SP - SP_OFS_PCL;
            mem_wdata_r <= CPU_PC[7:0];
            state_r <= LV_PUSH_L;
          end
        end
        LV_PUSH_L: begin
          if (MEM_ACK) begin
            mem_addr_r <= sp_r - SP_OFS_PCH;
            mem_wdata_r <= pc_r[15:8];
            state_r <= LV_PUSH_H;
          end
        end
        LV_PUSH_H: begin
          if (MEM_ACK) begin
            mem_addr_r <= sp_r - SP_OFS_FLG;
            mem_wdata_r <= flags_r;
            state_r <= LV_PUSH_F;
          end
        end
        LV_PUSH_F: begin
          if (MEM_ACK) begin
            mem_wr_r <= 1'b0;
            mem_addr_r <= {8'h00, vec_r};
            state_r <= LV_FETCH_H;
          end
        end
        LV_FETCH_H: begin
          if (MEM_ACK) begin
            hi_r <= MEM_RDATA;
            mem_addr_r <= {8'h00, vec_r + 8'h01};
            state_r <= LV_FETCH_L;
          end
        end
        LV_FETCH_L: begin
          if (MEM_ACK) begin
            mem_req_r <= 1'b0;
            pc_value_r <= {hi_r, MEM_RDATA};
            sp_value_r <= sp_r - SP_OFS_FLG;
            pc_load_r <= 1'b1;
            state_r <= LV_JUMP;
          end
        end
        LV_JUMP: begin
          in_svc_r <= 1'b0;
          state_r <= LV_IDLE;
        end
        default: begin
          state_r <= LV_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign SRC_PEND = pend_r;
  assign REQUEST_LEVEL_N = req_r;
  assign SYSTEM_MODE_GIE = gie_r;
  assign IN_SERVICE = in_svc_r;
  assign SVC_LEVEL = lvl_r;
  assign SVC_VECTOR = vec_r;
  assign MEM_REQ = mem_req_r;
  assign MEM_WR = mem_wr_r;
  assign MEM_ADDR = mem_addr_r;
  assign MEM_WDATA = mem_wdata_r;
  assign PC_LOAD = pc_load_r;
  assign PC_VALUE = pc_value_r;
  assign SP_VALUE = sp_value_r;
  assign RESET_REQ = reset_req_r;
  assign RESET_ADDR = reset_addr_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  rsvd_level_idle_a: assert property (!REQUEST_LEVEL_N[LVL_RSVD])
    else $error("reserved level shows a request");
  grant_disables_a: assert property (grant |=> !SYSTEM_MODE_GIE && IN_SERVICE)
    else $error("grant left global enable on");
  push_first_a: assert property (grant |=> MEM_REQ && MEM_WR && MEM_WDATA == $past(CPU_PC[7:0]) && MEM_ADDR == $past(CPU_SP) - SP_OFS_PCL)
    else $error("first push wrong");
  vector_join_a: assert property (PC_LOAD |-> PC_VALUE == {hi_r, $past(MEM_RDATA)} && $past(MEM_ADDR) == {8'h00, vec_r + 8'h01})
    else $error("handler address not joined from vector bytes");
  hw_clear_a: assert property (grant && SRC_HW_CLR[win_src] && !SRC_EVENT[win_src] |=> !SRC_PEND[$past(win_src)])
    else $error("hardware pending bit not cleared");
  low_vec_a: assert property (grant && win_lvl == 3'h0 && act[SRC_T0_OVF] |-> win_vec == VEC_T0_OVF)
    else $error("level 0 did not take lowest vector");
  pin_vec_a: assert property (grant && win_lvl == 3'h6 && act[SRC_P0_0] |-> win_vec == VEC_P0_0)
    else $error("pin 0 vector not chosen");
  shared_vec_a: assert property (grant && win_lvl == 3'h7 |-> win_vec == VEC_P0_HI)
    else $error("shared pin vector wrong");
  mask_gate_a: assert property (grant |-> LEVEL_MASK_REG[win_lvl] && SYSTEM_MODE_GIE && lvl_raw[win_lvl])
    else $error("masked or disabled level granted");
  gie_on_cause_a: assert property ($rose(SYSTEM_MODE_GIE) |-> $past(GLOBAL_INT_ON_INSTR))
    else $error("global enable rose without on instruction");
  sub_a_order_a: assert property (grant && LEVEL_PRIORITY_REG[PRIO_SUB_A] && elig[1] && win_lvl[2:1] == 2'b00 |-> win_lvl == 3'h1)
    else $error("group A subgroup order ignored");
  bt_reset_a: assert property (bt_fire |=> RESET_REQ && RESET_ADDR == RESET_VECTOR)
    else $error("basic timer reset not requested");

  grant_lvl0_c: cover property (grant && win_lvl == 3'h0);
  grant_lvl7_c: cover property (grant && win_lvl == 3'h7);
  full_service_c: cover property (grant ##[6:40] PC_LOAD);
  bt_reset_c: cover property (RESET_REQ);

endmodule

// ===== src/lvic_level_pick.sv
`timescale 1ns/10ps
// fixed in-level arbiter: position 0 is priority 0, the highest
module lvic_level_pick #(
  parameter int N = 1
) (
  lvic_pick_if.arb pk
);
  import lvic_pkg::*;

  localparam int IW = (N > 1) ? $clog2(N) : 1;

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (N < 1 || N > MAX_VEC_PER_LVL) begin : g_bad_n
    $error("lvic_level_pick: vector count out of range");
  end

  // ---------------------------------------------------------------
  // priority search
  // ---------------------------------------------------------------
  // zero wins first
  always_comb begin
    pk.any = 1'b0;
    pk.idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pk.req[i]) begin
        pk.any = 1'b1;
        pk.idx = IW'(i);
      end
    end
  end

endmodule

// ===== src/lvic_pick_if.sv
`timescale 1ns/10ps
// requests of one level and the winner inside it
interface lvic_pick_if #(parameter int N = 1);
  localparam int IW = (N > 1) ? $clog2(N) : 1;
  logic [N-1:0] req;
  logic any;
  logic [IW-1:0] idx;
  modport arb (input req, output any, output idx);
  modport user (output req, input any, input idx);
endinterface

// ===== src/lvic_pkg.sv
package lvic_pkg;

  // ---------------------------------------------------------------
  // structure sizes
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 17;
  localparam int NUM_LVL = 8;
  localparam int LVL_RSVD = 5;
  localparam int MAX_VEC_PER_LVL = 128;

  // ---------------------------------------------------------------
  // source positions in the pending vector
  // ---------------------------------------------------------------
  localparam int SRC_BT_OVF = 0;
  localparam int SRC_T0_OVF = 1;
  localparam int SRC_T0_MC = 2;
  localparam int SRC_T1_OVF = 3;
  localparam int SRC_T1_MC = 4;
  localparam int SRC_CA = 5;
  localparam int SRC_T2_OVF = 6;
  localparam int SRC_T2_MC = 7;
  localparam int SRC_P2_0 = 8;
  localparam int SRC_P0_0 = 9;
  localparam int SRC_P0_1 = 10;
  localparam int SRC_P0_2 = 11;
  localparam int SRC_P0_3 = 12;
  localparam int SRC_P0_4 = 13;
  localparam int SRC_P0_5 = 14;
  localparam int SRC_P0_6 = 15;
  localparam int SRC_P0_7 = 16;

  // sources whose pending bit hardware clears when service starts
  localparam logic [NUM_SRC-1:0] SRC_HW_CLR = 17'h0006B;

  // ---------------------------------------------------------------
  // vector addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] VEC_T0_MC = 8'hFC;
  localparam logic [7:0] VEC_T0_OVF = 8'hFA;
  localparam logic [7:0] VEC_T1_MC = 8'hF6;
  localparam logic [7:0] VEC_T1_OVF = 8'hF4;
  localparam logic [7:0] VEC_CA = 8'hEC;
  localparam logic [7:0] VEC_T2_MC = 8'hF2;
  localparam logic [7:0] VEC_T2_OVF = 8'hF0;
  localparam logic [7:0] VEC_P0_HI = 8'hE8;
  localparam logic [7:0] VEC_P0_0 = 8'hE0;
  localparam logic [7:0] VEC_P2_0 = 8'hD0;
  localparam logic [15:0] RESET_VEC_DFLT = 16'h0100;

  // ---------------------------------------------------------------
  // level priority register fields and group order codes
  // ---------------------------------------------------------------
  localparam int PRIO_ORD_HI = 7;
  localparam int PRIO_ORD_MID = 4;
  localparam int PRIO_ORD_LO = 1;
  localparam int PRIO_SUB_A = 0;
  localparam int PRIO_GRP_B = 2;
  localparam int PRIO_SUB_B = 3;
  localparam int PRIO_GRP_C = 5;
  localparam int PRIO_SUB_C = 6;
  localparam logic [2:0] ORD_BCA = 3'h1;
  localparam logic [2:0] ORD_ABC = 3'h2;
  localparam logic [2:0] ORD_BAC = 3'h3;
  localparam logic [2:0] ORD_CAB = 3'h4;
  localparam logic [2:0] ORD_CBA = 3'h5;
  localparam logic [2:0] ORD_ACB = 3'h6;

  // ---------------------------------------------------------------
  // stack frame offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] SP_OFS_PCL = 16'h0001;
  localparam logic [15:0] SP_OFS_PCH = 16'h0002;
  localparam logic [15:0] SP_OFS_FLG = 16'h0003;
  localparam logic GIE_RST = 1'b0;

  // service sequencer states
  typedef enum logic [2:0] {
    LV_IDLE = 3'b000,
    LV_PUSH_L = 3'b001,
    LV_PUSH_H = 3'b010,
    LV_PUSH_F = 3'b011,
    LV_FETCH_H = 3'b100,
    LV_FETCH_L = 3'b101,
    LV_JUMP = 3'b110
  } lvic_state_e;

endpackage

// ===== tb/lvic_cpu_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// cpu and memory side of the service sequencer
// ---------------------------------------------------------------
module lvic_cpu_model (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SLOW,
  input wire logic MEM_REQ,
  input wire logic MEM_WR,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic MEM_ACK,
  output logic [7:0] MEM_RDATA
);
  // plain array so that every simulator takes it; covers the whole address space
  logic [7:0] wmem [0:65535];
  int wait_c;

  // one access per ack, optional wait states, bus garbage when idle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      MEM_ACK <= 1'b0;
      MEM_RDATA <= 8'h00;
      wait_c <= 0;
    end else begin
      MEM_ACK <= 1'b0;
      if (MEM_REQ && !MEM_ACK) begin
        if (SLOW && wait_c < 2) begin
          wait_c <= wait_c + 1;
          MEM_RDATA <= ~MEM_RDATA;
        end else begin
          MEM_ACK <= 1'b1;
          wait_c <= 0;
          if (MEM_WR) begin
            wmem[MEM_ADDR] <= MEM_WDATA;
          end else begin
            MEM_RDATA <= MEM_ADDR[7:0] ^ 8'h5A;
          end
        end
      end else begin
        MEM_RDATA <= ~MEM_RDATA;
      end
    end
  end
endmodule

// ===== tb/lvic_ctrl_tb_top.sv
`timescale 1ns/10ps
module lvic_ctrl_tb_top;
  import lvic_pkg::*;
  logic clk, rst, on_i, off_i, bound, slow, gie, in_svc, mreq, mwr, mack, pc_load, rst_req;
  logic [NUM_SRC-1:0] ev, en, swc, pend;
  logic [NUM_LVL-1:0] mask, req_lvl;
  logic [7:0] prio, flags, wdata, rdata, svc_vec;
  logic [15:0] pc, sp, addr, pc_val, sp_val, rst_addr;
  logic [2:0] svc_lvl;
  int fails, compares, cycles;

  // ---------------------------------------------------------------
  // design and partner
  // ---------------------------------------------------------------
  lvic_ctrl i_lvic_ctrl (.CLK(clk), .RST(rst), .SRC_EVENT(ev), .SRC_EN(en), .SW_CLR(swc),
    .LEVEL_MASK_REG(mask), .LEVEL_PRIORITY_REG(prio), .GLOBAL_INT_ON_INSTR(on_i),
    .GLOBAL_INT_OFF_INSTR(off_i), .CPU_BOUNDARY(bound), .CPU_PC(pc), .CPU_FLAGS(flags),
    .CPU_SP(sp), .MEM_ACK(mack), .MEM_RDATA(rdata), .SRC_PEND(pend),
    .REQUEST_LEVEL_N(req_lvl), .SYSTEM_MODE_GIE(gie), .IN_SERVICE(in_svc),
    .SVC_LEVEL(svc_lvl), .SVC_VECTOR(svc_vec), .MEM_REQ(mreq), .MEM_WR(mwr),
    .MEM_ADDR(addr), .MEM_WDATA(wdata), .PC_LOAD(pc_load), .PC_VALUE(pc_val),
    .SP_VALUE(sp_val), .RESET_REQ(rst_req), .RESET_ADDR(rst_addr));
  lvic_cpu_model i_lvic_cpu_model (.CLK(clk), .RST(rst), .SLOW(slow), .MEM_REQ(mreq),
    .MEM_WR(mwr), .MEM_ADDR(addr), .MEM_WDATA(wdata), .MEM_ACK(mack), .MEM_RDATA(rdata));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [NUM_SRC-1:0] b(input int i);
    b = '0;
    b[i] = 1'b1;
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic fire(input logic [NUM_SRC-1:0] m);
    ev = m;
    cyc(1);
    ev = '0;
  endtask
  task automatic clr(input logic [NUM_SRC-1:0] m);
    swc = m;
    cyc(1);
    swc = '0;
  endtask
  task automatic gon;
    on_i = 1'b1;
    cyc(1);
    on_i = 1'b0;
  endtask
  // enable, grant at one boundary, follow the frame to the jump
  task automatic serve(input logic [2:0] lvl, input logic [7:0] vec);
    int n;
    pc = {8'h30, vec};
    flags = vec ^ 8'hFF;
    sp = 16'h0200 + {8'h00, vec};
    gon;
    bound = 1'b1;
    cyc(1);
    bound = 1'b0;
    chk("in_service", in_svc, 1);
    chk("gie", gie, 0);
    chk("svc_level", svc_lvl, lvl);
    chk("svc_vector", svc_vec, vec);
    n = 0;
    while (pc_load !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("pc_value", pc_val, {vec ^ 8'h5A, (vec + 8'h01) ^ 8'h5A});
    chk("sp_value", sp_val, sp - 16'h0003);
    chk("push pcl", i_lvic_cpu_model.wmem[sp - 16'h0001], pc[7:0]);
    chk("push pch", i_lvic_cpu_model.wmem[sp - 16'h0002], pc[15:8]);
    chk("push flags", i_lvic_cpu_model.wmem[sp - 16'h0003], flags);
    cyc(1);
    chk("in_service end", in_svc, 0);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("gie", gie, 0);
    chk("request", req_lvl, 0);
    chk("reset_addr", rst_addr, 16'h0100);
    $display("reset test done");
  endtask
  task automatic t_gie;
    gon;
    chk("gie on", gie, 1);
    off_i = 1'b1;
    cyc(1);
    off_i = 1'b0;
    chk("gie off", gie, 0);
    $display("enable test done");
  endtask
  task automatic t_pend;
    en[SRC_T1_MC] = 1'b0;
    fire(b(SRC_T0_MC) | b(SRC_T1_MC));
    chk("pend t0", pend[SRC_T0_MC], 1);
    cyc(1);
    chk("request", req_lvl, 8'h01);
    clr(b(SRC_T0_MC) | b(SRC_T1_MC));
    chk("pend cleared", pend, 0);
    en = '1;
    $display("pending test done");
  endtask
  task automatic t_level0;
    fire(b(SRC_T0_OVF) | b(SRC_T0_MC));
    serve(3'h0, VEC_T0_OVF);
    chk("ovf hw clear", pend[SRC_T0_OVF], 0);
    chk("mc kept", pend[SRC_T0_MC], 1);
    serve(3'h0, VEC_T0_MC);
    clr(b(SRC_T0_MC));
    $display("level zero test done");
  endtask
  task automatic t_prio;
    prio = 8'h82;
    slow = 1'b1;
    fire(b(SRC_P0_0) | b(SRC_P0_3) | b(SRC_T1_OVF) | b(SRC_T2_MC));
    serve(3'h6, VEC_P0_0);
    clr(b(SRC_P0_0));
    prio = 8'h00;
    slow = 1'b0;
    serve(3'h1, VEC_T1_OVF);
    serve(3'h3, VEC_T2_MC);
    // match source is cleared by software, else level 3 wins again
    clr(b(SRC_T2_MC));
    serve(3'h6, 8'hE6);
    clr('1);
    $display("priority test done");
  endtask
  task automatic t_mask;
    mask = 8'hFB;
    fire(b(SRC_CA) | b(SRC_P2_0) | b(SRC_P0_5));
    prio = 8'h04;
    serve(3'h4, VEC_P2_0);
    chk("p2 kept", pend[SRC_P2_0], 1);
    clr(b(SRC_P2_0));
    serve(3'h7, VEC_P0_HI);
    chk("p0 kept", pend[SRC_P0_5], 1);
    clr(b(SRC_P0_5));
    mask = '1;
    serve(3'h2, VEC_CA);
    chk("ca hw clear", pend[SRC_CA], 0);
    $display("mask test done");
  endtask
  task automatic t_btimer;
    fire(b(SRC_BT_OVF));
    cyc(1);
    chk("reset_req", rst_req, 1);
    chk("bt pend", pend[SRC_BT_OVF], 0);
    $display("basic timer test done");
  endtask
  // subgroup and group order codes not used elsewhere
  task automatic t_order;
    prio = 8'h01;
    fire(b(SRC_T0_OVF) | b(SRC_T1_OVF) | b(SRC_P0_1));
    serve(3'h1, VEC_T1_OVF);
    serve(3'h0, VEC_T0_OVF);
    prio = 8'h52;
    fire(b(SRC_CA) | b(SRC_T0_MC) | b(SRC_P0_7));
    serve(3'h2, VEC_CA);
    serve(3'h0, VEC_T0_MC);
    clr(b(SRC_T0_MC));
    serve(3'h7, VEC_P0_HI);
    clr(b(SRC_P0_7));
    serve(3'h6, 8'hE2);
    clr(b(SRC_P0_1));
    prio = 8'h00;
    $display("order test done");
  endtask
  // reset in mid service leaves sequencer and enable idle
  task automatic t_midrst;
    fire(b(SRC_T0_OVF));
    gon;
    bound = 1'b1;
    cyc(3);
    bound = 1'b0;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    chk("mid reset service", in_svc, 0);
    chk("mid reset mem_req", mreq, 0);
    chk("mid reset gie", gie, 0);
    chk("mid reset pend", pend, 0);
    chk("mid reset addr", rst_addr, RESET_VEC_DFLT);
    cyc(1);
    chk("first edge gie", gie, 0);
    chk("first edge service", in_svc, 0);
    $display("mid reset test done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      results;
    end
  end
  initial begin
    {rst, on_i, off_i, bound, slow} = 5'b10000;
    {ev, swc} = '0;
    en = '1;
    mask = '1;
    prio = 8'h00;
    {pc, sp, flags} = '0;
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    t_reset;
    t_gie;
    t_pend;
    t_level0;
    t_prio;
    t_mask;
    t_btimer;
    t_order;
    t_midrst;
    results;
  end
endmodule
